// [hw/ctrl_port_pkg.sv]
// Constants for the paged control port with write checksums
`default_nettype none
package ctrl_port_pkg;
	localparam logic [7:0] OFS_PAGE_SELECT = 8'h00;
	localparam logic [7:0] OFS_DEVICE_STATE = 8'h03;
	localparam logic [7:0] OFS_XOR_CHECKSUM = 8'h7d;
	localparam logic [7:0] OFS_CRC_CHECKSUM = 8'h7e;
	localparam logic [7:0] OFS_BOOK_SELECT = 8'h7f;
	localparam logic [7:0] BOOK_CHECKSUM = 8'h8c;
	localparam logic [7:0] PAGE_ZERO = 8'h00;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] DEVICE_STATE_RESET = 8'h10;
	localparam int STATE_LSB = 0;
	localparam int STATE_MSB = 1;
	localparam logic [1:0] STATE_DEEP_SLEEP = 2'h0;
	localparam logic [1:0] STATE_SLEEP = 2'h1;
	localparam logic [1:0] STATE_HIZ = 2'h2;
	localparam logic [1:0] STATE_PLAY = 2'h3;
	localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h4c;
endpackage
`default_nettype wire

// [hw/crc8_step.sv]
// One-byte CRC update, polynomial from the package
`default_nettype none
module crc8_step
	import ctrl_port_pkg::*;
(
	input wire logic [7:0] crc_i,
	input wire logic [7:0] data_i,
	output logic [7:0] crc_o
);
	always_comb begin
		logic [7:0] c;
		c = crc_i ^ data_i;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		crc_o = c;
	end
endmodule
`default_nettype wire

// [hw/paged_control_port_checksum.sv]
// I2C target control port with book/page selection and write checksums
`default_nettype none
module paged_control_port_checksum
	import ctrl_port_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
)(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic power_down_pin_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic [7:0] book_o,
	output logic [7:0] page_o,
	output logic [1:0] device_state_o
);
	// ************************************
	// Input synchronisers
	// ************************************
	logic [1:0] scl_s_q, sda_s_q, wake_s_q;
	logic scl_q, sda_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			wake_s_q <= 2'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_i};
			sda_s_q <= {sda_s_q[0], sda_i};
			wake_s_q <= {wake_s_q[0], power_down_pin_i};
			scl_q <= scl_s_q[1];
			sda_q <= sda_s_q[1];
		end
	end
	wire logic scl = scl_s_q[1];
	wire logic sda = sda_s_q[1];
	wire logic awake = wake_s_q[1];
	wire logic scl_rise = scl & ~scl_q;
	wire logic scl_fall = ~scl & scl_q;
	wire logic start_c = scl & scl_q & sda_q & ~sda;
	wire logic stop_c = scl & scl_q & ~sda_q & sda;

	// ************************************
	// Transfer state
	// ************************************
	typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK} st_t;
	st_t st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] sub_q, sub_d;
	logic ack_ok_q, ack_ok_d;
	logic sda_o_q, sda_o_d, sda_oe_q, sda_oe_d;
	logic [7:0] book_q, book_d, page_q, page_d, state_reg_q, state_reg_d;
	logic [7:0] crc_q, crc_d, xor_q, xor_d;
	logic [7:0] crc_next;
	logic [7:0] rd_byte;

	crc8_step u_crc (
		.crc_i(crc_q),
		.data_i(shift_q),
		.crc_o(crc_next)
	);

	always_comb begin
		rd_byte = 8'h00;
		if (sub_q == OFS_PAGE_SELECT) begin
			rd_byte = page_q;
		end else if (page_q == PAGE_ZERO && sub_q == OFS_BOOK_SELECT) begin
			rd_byte = book_q;
		end else if (book_q == 8'h00 && page_q == PAGE_ZERO && sub_q == OFS_DEVICE_STATE) begin
			rd_byte = state_reg_q;
		end else if (book_q == BOOK_CHECKSUM && page_q == PAGE_ZERO
				&& sub_q == OFS_CRC_CHECKSUM) begin
			rd_byte = crc_q;
		end else if (book_q == BOOK_CHECKSUM && page_q == PAGE_ZERO
				&& sub_q == OFS_XOR_CHECKSUM) begin
			rd_byte = xor_q;
		end
	end

	always_comb begin
		logic is_page_wr, is_book_wr, at_ck_page;
		is_page_wr = (sub_q == OFS_PAGE_SELECT);
		is_book_wr = (page_q == PAGE_ZERO) && (sub_q == OFS_BOOK_SELECT);
		at_ck_page = (book_q == BOOK_CHECKSUM) && (page_q == PAGE_ZERO);
		st_d = st_q;
		bit_d = bit_q;
		shift_d = shift_q;
		sub_d = sub_q;
		ack_ok_d = ack_ok_q;
		sda_o_d = sda_o_q;
		sda_oe_d = sda_oe_q;
		book_d = book_q;
		page_d = page_q;
		state_reg_d = state_reg_q;
		crc_d = crc_q;
		xor_d = xor_q;
		if (!awake) begin
			st_d = ST_IDLE;
			sda_oe_d = 1'b0;
		end else if (start_c) begin
			st_d = ST_ADDR;
			bit_d = 4'h0;
			sda_oe_d = 1'b0;
		end else if (stop_c) begin
			st_d = ST_IDLE;
			sda_oe_d = 1'b0;
		end else begin
			unique case (st_q)
				ST_IDLE: ;
				ST_ADDR, ST_SUB, ST_WDATA: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda};
						bit_d = bit_q + 4'h1;
					end
					if (scl_fall && bit_q == 4'h8) begin
						bit_d = 4'h0;
						if (st_q == ST_ADDR) begin
							ack_ok_d = (shift_q[7:1] == TARGET_ADDR);
							sda_oe_d = (shift_q[7:1] == TARGET_ADDR);
							st_d = (shift_q[7:1] == TARGET_ADDR) ? ST_ADDR_ACK : ST_IDLE;
						end else begin
							sda_oe_d = 1'b1;
							st_d = (st_q == ST_SUB) ? ST_SUB_ACK : ST_WDATA_ACK;
						end
						sda_o_d = 1'b0;
						if (st_q == ST_SUB) begin
							sub_d = shift_q;
						end
						if (st_q == ST_WDATA) begin
							if (!is_page_wr && !is_book_wr) begin
								crc_d = crc_next;
							end
							if (book_q == BOOK_CHECKSUM && page_q != PAGE_ZERO
									&& !is_page_wr) begin
								xor_d = xor_q ^ shift_q;
							end
							if (is_page_wr) begin
								page_d = shift_q;
							end else if (is_book_wr) begin
								book_d = shift_q;
							end else if (book_q == 8'h00 && page_q == PAGE_ZERO
									&& sub_q == OFS_DEVICE_STATE) begin
								state_reg_d = shift_q;
							end else if (at_ck_page && sub_q == OFS_CRC_CHECKSUM) begin
								crc_d = shift_q;
							end else if (at_ck_page && sub_q == OFS_XOR_CHECKSUM) begin
								xor_d = shift_q;
							end
						end
					end
				end
				ST_ADDR_ACK, ST_SUB_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						if (st_q == ST_ADDR_ACK && shift_q[0]) begin
							st_d = ST_RDATA;
							shift_d = rd_byte;
							sda_o_d = rd_byte[7];
							sda_oe_d = 1'b1;
							bit_d = 4'h1;
						end else begin
							if (st_q == ST_WDATA_ACK) begin
								sub_d = sub_q + 8'h01;
							end
							st_d = (st_q == ST_ADDR_ACK) ? ST_SUB : ST_WDATA;
							sda_oe_d = 1'b0;
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_q == 4'h8) begin
							sda_oe_d = 1'b0;
							st_d = ST_RDATA_ACK;
							sub_d = sub_q + 8'h01;
						end else begin
							sda_o_d = shift_q[7 - bit_q[2:0]];
							bit_d = bit_q + 4'h1;
						end
					end
				end
				ST_RDATA_ACK: begin
					if (scl_rise) begin
						ack_ok_d = ~sda;
					end
					if (scl_fall) begin
						if (ack_ok_q) begin
							st_d = ST_RDATA;
							shift_d = rd_byte;
							sda_o_d = rd_byte[7];
							sda_oe_d = 1'b1;
							bit_d = 4'h1;
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= ST_IDLE;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			sub_q <= 8'h00;
			ack_ok_q <= 1'b0;
			sda_o_q <= 1'b1;
			sda_oe_q <= 1'b0;
			book_q <= 8'h00;
			page_q <= 8'h00;
			state_reg_q <= DEVICE_STATE_RESET;
			crc_q <= 8'h00;
			xor_q <= 8'h00;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			sub_q <= sub_d;
			ack_ok_q <= ack_ok_d;
			sda_o_q <= sda_o_d;
			sda_oe_q <= sda_oe_d;
			book_q <= book_d;
			page_q <= page_d;
			state_reg_q <= state_reg_d;
			crc_q <= crc_d;
			xor_q <= xor_d;
		end
	end

	assign sda_o = sda_o_q;
	assign sda_oe_o = sda_oe_q;
	assign book_o = book_q;
	assign page_o = page_q;
	assign device_state_o = state_reg_q[STATE_MSB:STATE_LSB];

	// ************************************
	// Checks
	// ************************************
	property p_quiet_when_down;
		@(posedge clk_i) disable iff (!nrst_i) !awake |=> !sda_oe_q;
	endproperty
	a_quiet_when_down: assert property (p_quiet_when_down) else $error("drives while down");
	property p_read_keeps_crc;
		@(posedge clk_i) disable iff (!nrst_i) (st_q == ST_RDATA) |=> $stable(crc_q);
	endproperty
	a_read_keeps_crc: assert property (p_read_keeps_crc) else $error("read moved crc");
	property p_xor_book;
		@(posedge clk_i) disable iff (!nrst_i)
			(book_q != BOOK_CHECKSUM && $stable(book_q)) |=> $stable(xor_q);
	endproperty
	a_xor_book: assert property (p_xor_book) else $error("xor moved outside book");
	property p_page_wr;
		@(posedge clk_i) disable iff (!nrst_i)
			(st_q == ST_WDATA && scl_fall && bit_q == 4'h8 && sub_q == OFS_PAGE_SELECT
			&& awake && !start_c && !stop_c) |=> (page_q == $past(shift_q) && $stable(crc_q));
	endproperty
	a_page_wr: assert property (p_page_wr) else $error("page write wrong");
	property p_sub_inc;
		@(posedge clk_i) disable iff (!nrst_i)
			(st_q == ST_WDATA_ACK && st_d == ST_WDATA) |=> sub_q == $past(sub_q) + 8'h01;
	endproperty
	a_sub_inc: assert property (p_sub_inc) else $error("subaddress not advanced");
	property p_rd_inc;
		@(posedge clk_i) disable iff (!nrst_i)
			(st_q == ST_RDATA && st_d == ST_RDATA_ACK) |=> sub_q == $past(sub_q) + 8'h01;
	endproperty
	a_rd_inc: assert property (p_rd_inc) else $error("read subaddress not advanced");
	property p_book_wr;
		@(posedge clk_i) disable iff (!nrst_i)
			(st_q == ST_WDATA && st_d == ST_WDATA_ACK && page_q == PAGE_ZERO
			&& sub_q == OFS_BOOK_SELECT) |=> book_q == $past(shift_q);
	endproperty
	a_book_wr: assert property (p_book_wr) else $error("book write wrong");
	property p_crc_upd;
		@(posedge clk_i) disable iff (!nrst_i)
			(st_q == ST_WDATA && st_d == ST_WDATA_ACK && sub_q != OFS_PAGE_SELECT
			&& !(page_q == PAGE_ZERO && sub_q >= OFS_CRC_CHECKSUM))
			|=> crc_q == $past(crc_next);
	endproperty
	a_crc_upd: assert property (p_crc_upd) else $error("crc not updated");
endmodule
`default_nettype wire

// [verification/i2c_host_model.sv]
// I2C host controller model that drives the control port pins
`default_nettype none
module i2c_host_model #(
	parameter logic [6:0] ADDR = 7'h4c
)(
	input wire logic clk_i,
	input wire logic sda_i,
	output var logic scl_o,
	output var logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bus released; called once by the bench so one process drives the pins
	task automatic idle;
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	endtask
	// Ten cycles keeps each clock phase above the target's minimum
	task automatic hp;
		repeat (10) @(negedge clk_i);
	endtask
	task automatic start;
		sda_low_o = 1'b0;
		hp;
		scl_o = 1'b1;
		hp;
		sda_low_o = 1'b1;
		hp;
		scl_o = 1'b0;
	endtask
	task automatic stop;
		hp;
		sda_low_o = 1'b1;
		hp;
		scl_o = 1'b1;
		hp;
		sda_low_o = 1'b0;
		hp;
	endtask
	// Data only moves while the clock is low, so no false start or stop
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		logic [8:0] s;
		s = {d, ack_in};
		for (int i = 8; i >= 0; i--) begin
			hp;
			sda_low_o = ~s[i];
			hp;
			scl_o = 1'b1;
			hp;
			s[i] = sda_i;
			scl_o = 1'b0;
		end
		q = s[8:1];
		ack = s[0];
	endtask
	task automatic hdr(input logic [7:0] sub, output int naks);
		logic [7:0] q;
		logic a;
		start;
		xfer({ADDR, 1'b0}, 1'b1, q, a);
		naks = int'(a);
		xfer(sub, 1'b1, q, a);
		naks += int'(a);
	endtask
	task automatic wr(input logic [7:0] sub, input logic [7:0] d[$], output int naks);
		logic [7:0] q;
		logic a;
		hdr(sub, naks);
		foreach (d[i]) begin
			xfer(d[i], 1'b1, q, a);
			naks += int'(a);
		end
		stop;
	endtask
	task automatic rd(input logic [7:0] sub, input int n, output logic [7:0] q[$],
		output int naks);
		logic [7:0] b;
		logic a;
		q = {};
		hdr(sub, naks);
		start;
		xfer({ADDR, 1'b1}, 1'b1, b, a);
		naks += int'(a);
		for (int i = 0; i < n; i++) begin
			xfer(8'hff, i == n - 1, b, a);
			q.push_back(b);
		end
		stop;
	endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the paged control port
`default_nettype none
module tb
	import ctrl_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] data; logic [1:0] st;} row_t;
	row_t rows[4] = '{'{8'h10, 2'h0}, '{8'h11, 2'h1}, '{8'h03, 2'h3}, '{8'h02, 2'h2}};
	logic [7:0] d5[$] = '{8'h08, 8'h25, 8'h39, 8'hce, 8'hf0};
	logic clk;
	logic nrst;
	logic pwr_up;
	logic scl;
	logic sda_low;
	logic sda_oe;
	logic sda_o;
	wire logic sda;
	logic [7:0] book;
	logic [7:0] page;
	logic [1:0] state;
	logic [7:0] q[$];
	logic [7:0] crc;
	logic [7:0] xsum;
	int errors = 0;
	int comparisons = 0;
	int n;
	// Open-drain wire with pull-up
	assign sda = ~(sda_low | (sda_oe & ~sda_o));
	paged_control_port_checksum u_dut (.clk_i(clk), .nrst_i(nrst), .scl_i(scl),
		.sda_i(sda), .power_down_pin_i(pwr_up), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.book_o(book), .page_o(page), .device_state_o(state));
	i2c_host_model #(.ADDR(TARGET_ADDR_DEFAULT)) u_host (.clk_i(clk), .sda_i(sda),
		.scl_o(scl), .sda_low_o(sda_low));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
		return c;
	endfunction
	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		nrst = 1'b0;
		pwr_up = 1'b1;
		u_host.idle;
		repeat (3) @(negedge clk);
		chk("oe", 8'h00, {7'h0, sda_oe});
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		chk("book", 8'h00, book);
		chk("page", 8'h00, page);
		chk("state", 8'h00, {6'h0, state});
		u_host.rd(OFS_DEVICE_STATE, 1, q, n);
		chk("state_reg", 8'h10, q[0]);
		$display("test reset done");
		foreach (rows[i]) begin
			u_host.wr(OFS_DEVICE_STATE, '{rows[i].data}, n);
			chk("naks", 8'h00, n[7:0]);
			chk("state", {6'h0, rows[i].st}, {6'h0, state});
			u_host.rd(OFS_DEVICE_STATE, 1, q, n);
			chk("readback", rows[i].data, q[0]);
		end
		$display("test rows done");
		u_host.wr(8'h00, '{8'h00}, n);
		u_host.wr(8'h7f, '{8'h8c}, n);
		chk("book", 8'h8c, book);
		u_host.wr(8'h7d, '{8'h00, 8'h00}, n);
		u_host.wr(8'h10, '{8'h5a}, n);
		crc = crc8(8'h00, 8'h5a);
		xsum = 8'h00;
		u_host.wr(8'h00, '{8'h01}, n);
		chk("page", 8'h01, page);
		u_host.wr(8'h18, d5, n);
		chk("naks", 8'h00, n[7:0]);
		foreach (d5[i]) begin
			crc = crc8(crc, d5[i]);
			xsum = xsum ^ d5[i];
		end
		u_host.rd(8'h18, 2, q, n);
		chk("blank", 8'h00, q[1]);
		u_host.wr(8'h00, '{8'h00}, n);
		// Book write must leave the CRC alone
		u_host.wr(OFS_BOOK_SELECT, '{BOOK_CHECKSUM}, n);
		u_host.rd(8'h7c, 3, q, n);
		chk("blank", 8'h00, q[0]);
		chk("xor", xsum, q[1]);
		chk("crc", crc, q[2]);
		// XOR holds a nonzero sum here, so clearing it is visible
		u_host.wr(OFS_XOR_CHECKSUM, '{8'h00}, n);
		crc = crc8(crc, 8'h00);
		u_host.rd(OFS_XOR_CHECKSUM, 2, q, n);
		chk("xor", 8'h00, q[0]);
		chk("crc", crc, q[1]);
		$display("test checksums done");
		pwr_up = 1'b0;
		repeat (4) @(negedge clk);
		u_host.wr(8'h00, '{8'h07}, n);
		chk("naks", 8'h03, n[7:0]);
		chk("page", 8'h00, page);
		pwr_up = 1'b1;
		repeat (4) @(negedge clk);
		u_host.wr(8'h00, '{8'h07}, n);
		chk("page", 8'h07, page);
		$display("test power down done");
		// Mid-run reset must undo book, page and state
		nrst = 1'b0;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		chk("book", 8'h00, book);
		chk("page", 8'h00, page);
		chk("state", 8'h00, {6'h0, state});
		$display("test mid reset done");
		report_and_stop;
	end
	// Whole run needs well under one millisecond
	initial begin
		#2ms;
		errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
